// ==== verilog/fes_pkg.sv ====
// Package with register map, field positions, timing and carrier types of the event status block
// What this block does
// R1: Reading any of the four event status registers clears its flags.
// R2: With show bit set, masked events latch but never reach irq or pending.
// R3: CAS empty flag per ESF multiframe or every 24 frames in F12/F72, only without serial signaling.
// R4: Receive overflow flag set the moment any channel 1 receive data is lost.
// R5: Done sending flag when last bit left and transmit queue empty, HDLC mode only.
// R6: Queue empty before message end command aborts the frame and flags underrun.
// R7: After underrun the transmitter stays disabled until its status register is read.
// R8: Transmit multiframe begin flag at each transmitted multiframe start.
// R9: SS7 error limit flag; repeats while invalid frames caused it, until valid frame.
// R10: Line change flag on open rising edge or any short state change.
// R11: Sync regained on alignment-lost fall or simulation end in sync; gone on loss.
// R12: Multiframe regained/gone on lost-status edges in F12/F72; both during simulation.
// R13: Blue and red flags on rising status, or any change when change-report set.
// R14: Yellow flag on remote alarm rise; cleared flag on fall or simulation end without remote alarm.
// R15: Errored second flag when any enabled error source occurred within the second.
// R16: One second tick flag each time the receive-clock based timer expires.
// R17: Without PRBS select, flag loop-back code held 33,16 ms, and flag on leaving.
// R18: With PRBS select, flag each PRBS sync change and report it as up state.
// R19: Receive slip negative and positive flags; both set during alarm simulation.
// R20: Transmit slip positive and negative flags from transmit slip events.
// R21: Channel 2 message end flag; channel 2 queue byte count readable.
// R22: Channel 2 frame start flag two bytes after a valid frame start.
// R23: Global pending register has one bit per register with unmasked pending event.
// R24: Interrupt pin active while any unmasked flag is set, released after reads.
package fes_pkg;
  // Register indexes; the byte address on the bus is four times the index
  localparam logic [7:0] IDX_TXH1 = 8'h69;
  localparam logic [7:0] IDX_ALARM = 8'h6a;
  localparam logic [7:0] IDX_PERF = 8'h6b;
  localparam logic [7:0] IDX_SLIP = 8'h6c;
  localparam logic [7:0] IDX_GLOBAL = 8'h6e;
  localparam logic [7:0] IDX_RXCNT2 = 8'h90;
  localparam logic [7:0] IDX_MASK0 = 8'h80;
  localparam logic [7:0] IDX_CTL = 8'h84;
  localparam logic [7:0] IDX_ERRMASK = 8'h85;
  localparam logic [7:0] IDX_LIVE = 8'h86;
  localparam logic [7:0] FLAG_IDX [4] = '{8'h69, 8'h6a, 8'h6b, 8'h6c};
  // Reset values: everything masked so nothing fires before software sets up
  localparam logic [7:0] MASK_RST = 8'hff;
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] ERRMASK_RST = 8'h00;
  localparam logic [7:0] FLAG_RST = 8'h00;
  // Control register fields
  localparam int CTL_SHOW = 0;
  localparam int CTL_SCI = 1;
  localparam int CTL_PRBS = 2;
  localparam int CTL_SERSIG = 3;
  localparam int CTL_HDLC = 4;
  localparam int CTL_SS7 = 5;
  localparam int CTL_FMT = 6;
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int LLB_PERSIST_US = 33160;
  localparam int LLB_PERSIST_CYC = LLB_PERSIST_US * CLK_MHZ;
  localparam int RX_TICKS_PER_S = 1544000;
  localparam logic [4:0] CAS_LAST_FRAME = 5'h17;
  localparam logic [1:0] RFS_DELAY_BYTES = 2'h2;
  typedef enum logic [1:0] {FMT_OTHER, FMT_ESF, FMT_F12, FMT_F72} fes_fmt_e;
  // Status levels from the line monitors and transmitter, all on clk
  typedef struct packed {
    logic sync_gone_flag;
    logic multi_sync_gone_flag;
    logic blue_alarm_flag;
    logic red_alarm_flag;
    logic remote_alarm_state;
    logic txOpen;
    logic txShort;
    logic prbsSync;
    logic llbCode;
    logic llbKindUp;
    logic alarmSim;
    logic txQueueEmpty;
  } fes_lvl_s;
  // One-cycle event pulses from the detectors, all on clk
  typedef struct packed {
    logic txMultiStart;
    logic txFrameStart;
    logic txPoolReady;
    logic rxOvf1;
    logic lastBitSent;
    logic txRanEmpty;
    logic txMsgEnd;
    logic txFrameBegin;
    logic suErrExceed;
    logic suInvalid;
    logic suValid;
    logic suFrameTick;
    logic framingErr;
    logic crcErr;
    logic codeViol;
    logic rxSlipNeg;
    logic rxSlipPos;
    logic txSlipNeg;
    logic txSlipPos;
    logic rxMsgEnd2;
    logic rxStart2;
    logic rxByte2;
    logic rxOvf2;
    logic doneSending2;
    logic txUnderrun2;
    logic rxPoolFull2;
    logic rxTick;
  } fes_evt_s;
endpackage

// ==== verilog/fes_event_regs.sv ====
// Read-to-clear event status registers with masks, pending summary and interrupt pin
`timescale 1ns/1ps
`default_nettype none
module fes_event_regs
  import fes_pkg::*;
#(
  parameter int unsigned LLB_CYC = LLB_PERSIST_CYC,
  parameter int unsigned ONE_S_TICKS = RX_TICKS_PER_S
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [9:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire fes_lvl_s lvl,
  input wire fes_evt_s evt,
  input wire logic [7:0] rxCountCh2,
  output logic irqPin,
  output logic txAbortReq,
  output logic txChanOff
);
  logic [7:0] flags [4];
  logic [7:0] mask [4];
  logic [7:0] setVec [4];
  logic [7:0] rdPart [4];
  logic [3:0] clrVec;
  logic [3:0] pending;
  logic [7:0] ctl;
  logic [7:0] errMask;
  fes_lvl_s lvlQ;
  logic [4:0] casCnt;
  logic msgEndSeen;
  logic frameOn;
  logic suLatch;
  logic [21:0] secCnt;
  logic secTick;
  logic esLatch;
  logic [21:0] llbCnt;
  logic llbDet;
  logic llbUp;
  logic [1:0] rfsCnt;
  logic loopbackUpState;
  logic loopbackDownState;

  // Bus decode; the register index sits above the two byte-offset bits
  wire [7:0] idx = address[9:2];
  wire aligned = address[1:0] == 2'h0;
  wire reqOn = read | write;
  wire serve = reqOn & ~waitrequest;
  wire wrOn = serve & write & byteenable[0] & aligned;
  wire show = ctl[CTL_SHOW];
  wire any_change_report_bit = ctl[CTL_SCI];
  wire prbsSel = ctl[CTL_PRBS];
  wire fes_fmt_e fmt = fes_fmt_e'(ctl[CTL_FMT+1:CTL_FMT]);
  wire fmtMulti = (fmt == FMT_F12) | (fmt == FMT_F72);
  wire sim = lvl.alarmSim;
  wire simEnd = lvlQ.alarmSim & ~lvl.alarmSim;

  // Channel 1 transmit and receive events
  wire casSet = ~ctl[CTL_SERSIG] & (((fmt == FMT_ESF) & evt.txMultiStart) |
    (fmtMulti & evt.txFrameStart & (casCnt == CAS_LAST_FRAME))); // R3
  wire doneSet = ctl[CTL_HDLC] & evt.lastBitSent & lvl.txQueueEmpty; // R5
  wire underrun = evt.txRanEmpty & frameOn & ~msgEndSeen & ~txChanOff; // R6
  wire suSet = ctl[CTL_SS7] & (evt.suErrExceed | (suLatch & evt.suFrameTick)); // R9
  wire lineSet = (lvl.txOpen & ~lvlQ.txOpen) | (lvl.txShort ^ lvlQ.txShort); // R10
  assign setVec[0] = {casSet, evt.rxOvf1, doneSet, underrun, evt.txMultiStart,
    suSet, lineSet, evt.txPoolReady}; // R4 R8

  // Alarm and synchronisation monitors
  wire farSet = (lvlQ.sync_gone_flag & ~lvl.sync_gone_flag) | (simEnd & ~lvl.sync_gone_flag); // R11
  wire lfaSet = (lvl.sync_gone_flag & ~lvlQ.sync_gone_flag) | sim; // R11
  wire mfarSet = fmtMulti & ((lvlQ.multi_sync_gone_flag & ~lvl.multi_sync_gone_flag) | sim); // R12
  wire lmfaSet = fmtMulti & ((lvl.multi_sync_gone_flag & ~lvlQ.multi_sync_gone_flag) | sim); // R12
  wire aisSet = (any_change_report_bit ? (lvl.blue_alarm_flag ^ lvlQ.blue_alarm_flag) : (lvl.blue_alarm_flag & ~lvlQ.blue_alarm_flag)) | sim; // R13
  wire losSet = (any_change_report_bit ? (lvl.red_alarm_flag ^ lvlQ.red_alarm_flag) : (lvl.red_alarm_flag & ~lvlQ.red_alarm_flag)) | sim; // R13
  wire rarSet = (lvlQ.remote_alarm_state & ~lvl.remote_alarm_state) | (simEnd & ~lvl.remote_alarm_state); // R14
  wire raSet = (lvl.remote_alarm_state & ~lvlQ.remote_alarm_state) | sim; // R14
  assign setVec[1] = {farSet, lfaSet, mfarSet, lmfaSet, aisSet, losSet, rarSet, raSet};

  // Performance events; errored sources in mask order lfa,fer,cer,ais,los,cv,slip
  wire slipAny = evt.rxSlipNeg | evt.rxSlipPos | evt.txSlipNeg | evt.txSlipPos;
  wire [6:0] errSrc = {lvl.sync_gone_flag, evt.framingErr, evt.crcErr, lvl.blue_alarm_flag, lvl.red_alarm_flag,
    evt.codeViol, slipAny};
  wire errHit = |(errSrc & errMask[6:0]); // R15
  wire esSet = secTick & (esLatch | errHit); // R15
  wire llbEnter = ~prbsSel & ~llbDet & lvl.llbCode & (llbCnt == 22'(LLB_CYC - 1)); // R17
  wire llbLeave = ~prbsSel & llbDet & ~lvl.llbCode; // R17
  wire prbsChg = prbsSel & (lvl.prbsSync ^ lvlQ.prbsSync); // R18
  wire llbSet = llbEnter | llbLeave | prbsChg;
  assign setVec[2] = {esSet, secTick, 3'h0, llbSet, evt.rxSlipNeg | sim,
    evt.rxSlipPos | sim}; // R16 R19

  // Transmit slips and HDLC channel 2
  wire rfsSet = evt.rxByte2 & ~evt.rxStart2 & (rfsCnt == 2'h1); // R22
  assign setVec[3] = {evt.txSlipPos, evt.txSlipNeg, evt.rxMsgEnd2, rfsSet, evt.rxOvf2,
    evt.doneSending2, evt.txUnderrun2, evt.rxPoolFull2}; // R20 R21

  // Per-register flags, masks, read-back and pending summary
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_reg
      // Only bits handed out in readdata are cleared, so an event landing
      // between capture and the answer edge survives for the next read
      wire hitFlag = aligned & (idx == FLAG_IDX[gi]);
      wire hitMask = aligned & (idx == IDX_MASK0 + 8'(gi));
      wire [7:0] latchOk = ~mask[gi] | {8{show}}; // R2
      wire [7:0] clrBits = clrVec[gi] ? readdata[7:0] : 8'h00;
      assign clrVec[gi] = serve & read & hitFlag; // R1
      assign rdPart[gi] = (hitFlag ? flags[gi] : 8'h00) | (hitMask ? mask[gi] : 8'h00);
      assign pending[gi] = |(flags[gi] & ~mask[gi]); // R23
      // Set wins over the read clear
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          flags[gi] <= FLAG_RST;
          mask[gi] <= MASK_RST;
        end else begin
          flags[gi] <= (flags[gi] & ~clrBits) | (setVec[gi] & latchOk); // R1 R2
          if (wrOn & hitMask) begin
            mask[gi] <= writedata[7:0];
          end
        end
      end
    end
  endgenerate

  // Read mux; unmapped or misaligned reads answer zero
  wire [7:0] globalByte = {3'h0, pending, 1'b0}; // R23
  wire [7:0] liveByte = {5'h0, txChanOff, loopbackDownState, loopbackUpState};
  wire [7:0] rdByte = rdPart[0] | rdPart[1] | rdPart[2] | rdPart[3] |
    ((aligned & (idx == IDX_GLOBAL)) ? globalByte : 8'h00) |
    ((aligned & (idx == IDX_RXCNT2)) ? rxCountCh2 : 8'h00) | // R21
    ((aligned & (idx == IDX_CTL)) ? ctl : 8'h00) |
    ((aligned & (idx == IDX_ERRMASK)) ? errMask : 8'h00) |
    ((aligned & (idx == IDX_LIVE)) ? liveByte : 8'h00);

  // Avalon handshake: capture on the first edge, act and release on the second
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      waitrequest <= 1'b1;
      readdata <= 32'h0;
    end else begin
      waitrequest <= ~(reqOn & waitrequest);
      if (read & waitrequest) begin
        readdata <= {24'h0, rdByte};
      end
    end
  end

  // Software control registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctl <= CTL_RST;
      errMask <= ERRMASK_RST;
    end else begin
      if (wrOn & aligned & (idx == IDX_CTL)) ctl <= writedata[7:0];
      if (wrOn & aligned & (idx == IDX_ERRMASK)) errMask <= writedata[7:0];
    end
  end

  // Interrupt pin follows the pending summary one cycle later
  always_ff @(posedge clk) begin
    if (!rst_b) irqPin <= 1'b0;
    else irqPin <= |pending; // R24
  end

  // Previous levels for edge detection; inputs share clk so need no synchroniser
  always_ff @(posedge clk) begin
    if (!rst_b) lvlQ <= '0;
    else lvlQ <= lvl;
  end

  // CAS frame counter wraps every 24 transmitted frames
  always_ff @(posedge clk) begin
    if (!rst_b) casCnt <= 5'h0;
    else if (evt.txFrameStart) casCnt <= (casCnt == CAS_LAST_FRAME) ? 5'h0 : casCnt + 5'h1; // R3
  end

  // Underrun tracking; the channel stays off until software reads the register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      msgEndSeen <= 1'b0;
      frameOn <= 1'b0;
      txChanOff <= 1'b0;
      txAbortReq <= 1'b0;
    end else begin
      if (evt.txFrameBegin) msgEndSeen <= 1'b0;
      else if (evt.txMsgEnd) msgEndSeen <= 1'b1;
      if (evt.txFrameBegin & ~txChanOff) frameOn <= 1'b1;
      else if (evt.lastBitSent | underrun) frameOn <= 1'b0;
      txAbortReq <= underrun; // R6
      if (underrun) txChanOff <= 1'b1; // R7
      else if (clrVec[0]) txChanOff <= 1'b0; // R7
    end
  end

  // A limit reached through invalid frames repeats until a valid frame arrives
  always_ff @(posedge clk) begin
    if (!rst_b) suLatch <= 1'b0;
    else if (evt.suErrExceed & evt.suInvalid) suLatch <= 1'b1; // R9
    else if (evt.suValid) suLatch <= 1'b0;
  end

  // One-second timer counts receive line clock enables, not clk cycles
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      secCnt <= 22'h0;
      secTick <= 1'b0;
      esLatch <= 1'b0;
    end else begin
      secTick <= evt.rxTick & (secCnt == 22'(ONE_S_TICKS - 1)); // R16
      if (evt.rxTick) secCnt <= (secCnt == 22'(ONE_S_TICKS - 1)) ? 22'h0 : secCnt + 22'h1;
      esLatch <= secTick ? 1'b0 : (esLatch | errHit); // R15
    end
  end

  // Loop-back code persistence; error rate is judged upstream in llbCode
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      llbCnt <= 22'h0;
      llbDet <= 1'b0;
      llbUp <= 1'b0;
    end else begin
      llbCnt <= (lvl.llbCode & ~llbDet & ~llbEnter) ? llbCnt + 22'h1 : 22'h0;
      if (llbEnter) begin
        llbDet <= 1'b1; // R17
        llbUp <= lvl.llbKindUp;
      end else if (llbLeave | prbsSel) begin
        llbDet <= 1'b0;
      end
    end
  end

  // Up state shows PRBS sync when PRBS is selected
  always_comb begin
    loopbackUpState = prbsSel ? lvlQ.prbsSync : (llbDet & llbUp); // R18
    loopbackDownState = ~prbsSel & llbDet & ~llbUp;
  end

  // Channel 2 frame start counts two received bytes after a valid start
  always_ff @(posedge clk) begin
    if (!rst_b) rfsCnt <= 2'h0;
    else if (evt.rxStart2) rfsCnt <= RFS_DELAY_BYTES; // R22
    else if (evt.rxByte2 & (rfsCnt != 2'h0)) rfsCnt <= rfsCnt - 2'h1;
  end

  // Checks
  sequence s_under;
    underrun ##1 txChanOff;
  endsequence
  a_read_clears: assert property (@(posedge clk) disable iff (!rst_b) // R1
    (clrVec[0] && setVec[0] == 8'h00) |=> (flags[0] & $past(readdata[7:0])) == 8'h00)
    else $error("status bits survived a clearing read");
  a_masked_latch: assert property (@(posedge clk) disable iff (!rst_b) // R2
    (raSet && show && mask[1] == 8'hff && !wrOn) |=> flags[1][0] && !pending[1])
    else $error("masked event not latched or shown pending");
  a_cas_serial: assert property (@(posedge clk) disable iff (!rst_b) // R3
    $rose(flags[0][7]) |-> $past(!ctl[CTL_SERSIG]))
    else $error("cas flag raised with serial signaling enabled");
  a_done_hdlc: assert property (@(posedge clk) disable iff (!rst_b) // R5
    $rose(flags[0][5]) |-> $past(ctl[CTL_HDLC] && lvl.txQueueEmpty))
    else $error("done flag outside hdlc mode or with data queued");
  a_underrun_abort: assert property (@(posedge clk) disable iff (!rst_b) // R6
    s_under |-> txAbortReq && $past(underrun, 1))
    else $error("underrun without abort request");
  a_chan_held: assert property (@(posedge clk) disable iff (!rst_b) // R7
    (txChanOff && !clrVec[0]) |=> txChanOff)
    else $error("transmitter re-enabled without status read");
  a_line_change: assert property (@(posedge clk) disable iff (!rst_b) // R10
    ((lvl.txShort != lvlQ.txShort) && (!mask[0][1] || show)) |=> flags[0][1])
    else $error("line short change not flagged");
  a_sync_lost: assert property (@(posedge clk) disable iff (!rst_b) // R11
    (lvl.sync_gone_flag && !lvlQ.sync_gone_flag && (!mask[1][6] || show)) |=> flags[1][6])
    else $error("loss of alignment not flagged");
  a_sec_period: assert property (@(posedge clk) disable iff (!rst_b) // R16
    secTick |-> $past(evt.rxTick) && $past(secCnt) == 22'(ONE_S_TICKS - 1))
    else $error("second tick at wrong count");
  a_start_delay: assert property (@(posedge clk) disable iff (!rst_b) // R22
    (evt.rxStart2 ##1 (!evt.rxStart2 && evt.rxByte2) ##1 (!evt.rxStart2 && evt.rxByte2))
    |-> rfsSet)
    else $error("frame start flag not two bytes after start");
  a_irq_follows: assert property (@(posedge clk) disable iff (!rst_b) // R24
    ##1 irqPin == $past(|pending))
    else $error("interrupt pin disagrees with pending events");
endmodule
`default_nettype wire

// ==== verif/fes_event_regs_test.sv ====
// Self-checking bench for the event status register block
`timescale 1ns/1ps
`default_nettype none
module fes_event_regs_test
  import fes_pkg::*;
;
  logic clk, rst_b, read, write, waitrequest, irqPin, txAbortReq, txChanOff;
  logic [9:0] address;
  logic [31:0] writedata, readdata;
  logic [3:0] byteenable;
  logic [7:0] rxCountCh2, cnt, k;
  fes_lvl_s lvl, lvlNow;
  fes_evt_s evt;
  int err_total, total_checks, seed, cyc;
  // Event pulse table: register index and bit each pulse should set
  localparam logic [7:0] TAB_IDX [9] = '{8'h69, 8'h69, 8'h69, 8'h6b, 8'h6b, 8'h6c, 8'h6c,
    8'h6c, 8'h6c};
  localparam int TAB_BIT [9] = '{3, 6, 0, 1, 0, 7, 6, 5, 3};

  // Short counts keep the loop-back and one-second timers quick
  fes_event_regs #(.LLB_CYC(20), .ONE_S_TICKS(10)) dut_u (.clk(clk), .rst_b(rst_b),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest), .lvl(lvl),
    .evt(evt), .rxCountCh2(rxCountCh2), .irqPin(irqPin), .txAbortReq(txAbortReq),
    .txChanOff(txChanOff));

  function automatic logic [7:0] bitv(input int b);
    return 8'h01 << b;
  endfunction

  // Map a pulse code to the detector field it raises
  function automatic fes_evt_s mkEvt(input int c);
    fes_evt_s e;
    e = '0;
    case (c)
      0: e.txMultiStart = 1'b1;
      1: e.rxOvf1 = 1'b1;
      2: e.txPoolReady = 1'b1;
      3: e.rxSlipNeg = 1'b1;
      4: e.rxSlipPos = 1'b1;
      5: e.txSlipPos = 1'b1;
      6: e.txSlipNeg = 1'b1;
      7: e.rxMsgEnd2 = 1'b1;
      8: e.rxOvf2 = 1'b1;
      9: e.txFrameBegin = 1'b1;
      10: e.txMsgEnd = 1'b1;
      11: e.txRanEmpty = 1'b1;
      12: e.lastBitSent = 1'b1;
      13: e.rxStart2 = 1'b1;
      14: e.rxByte2 = 1'b1;
      15: e.rxTick = 1'b1;
      16: e.codeViol = 1'b1;
      18: begin
        e.suErrExceed = 1'b1;
        e.suInvalid = 1'b1;
      end
      19: e.suFrameTick = 1'b1;
      20: e.suValid = 1'b1;
      default: e.txFrameStart = 1'b1;
    endcase
    return e;
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One Avalon transfer; request held until waitrequest is seen low, hang guard ends a stall
  task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] wd,
    output logic [7:0] q);
    @(posedge clk);
    address <= {idx, 2'b00};
    read <= ~wr;
    write <= wr;
    writedata <= {24'h0, wd};
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    q = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    bus(idx, 1'b0, 8'h00, q);
    chk(q, exp);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(idx, 1'b1, d, q);
  endtask

  task automatic ev(input int c);
    @(posedge clk);
    evt <= mkEvt(c);
    @(posedge clk);
    evt <= '0;
  endtask

  task automatic lv();
    @(posedge clk);
    lvl <= lvlNow;
    repeat (2) @(posedge clk);
  endtask

  task automatic endT(input string s);
    $display("test %s done, checks %0d", s, total_checks);
  endtask

  // Free-running clock and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end

  initial begin
    {rst_b, read, write, address, writedata, rxCountCh2, evt, lvl, lvlNow} = '0;
    byteenable = 4'hf;
    {err_total, total_checks, cyc} = '0;
    seed = 65;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    // Reset contents, plus an unmapped index that must read zero
    for (int i = 0; i < 4; i++) begin
      rchk(IDX_MASK0 + 8'(i), MASK_RST);
      rchk(FLAG_IDX[i], FLAG_RST);
    end
    rchk(IDX_CTL, CTL_RST);
    rchk(IDX_ERRMASK, ERRMASK_RST);
    rchk(IDX_GLOBAL, 8'h00);
    rchk(8'h70, 8'h00);
    endT("reset");
    // Masked events: dropped without show bit, latched but silent with it
    ev(3);
    rchk(IDX_PERF, 8'h00);
    wr(IDX_CTL, 8'h01);
    ev(3);
    lvlNow.remote_alarm_state = 1'b1;
    lv();
    rchk(IDX_GLOBAL, 8'h00);
    chk({7'h0, irqPin}, 8'h00);
    rchk(IDX_PERF, 8'h02);
    rchk(IDX_ALARM, 8'h01);
    lvlNow.remote_alarm_state = 1'b0;
    lv();
    rchk(IDX_ALARM, 8'h02);
    for (int i = 0; i < 4; i++) wr(IDX_MASK0 + 8'(i), 8'h00);
    wr(IDX_CTL, 8'h00);
    endT("mask");
    // Random pulses: flag, pending bit, pin, clear on read
    repeat (30) begin
      k = 8'(($random(seed) & 32'h7fffffff) % 9);
      rxCountCh2 <= 8'($random(seed));
      ev(k);
      repeat (2) @(posedge clk);
      #1;
      chk({7'h0, irqPin}, 8'h01);
      rchk(IDX_GLOBAL, bitv(TAB_IDX[k] - 8'h68));
      rchk(TAB_IDX[k], bitv(TAB_BIT[k]));
      rchk(TAB_IDX[k], 8'h00);
      #1;
      chk({7'h0, irqPin}, 8'h00);
      rchk(IDX_RXCNT2, rxCountCh2);
    end
    endT("random");
    // Ended frame and non-HDLC last bit give nothing; bare queue run-out underruns
    lvlNow.txQueueEmpty = 1'b1;
    lv();
    ev(9);
    ev(10);
    ev(11);
    ev(12);
    rchk(IDX_TXH1, 8'h00);
    ev(9);
    cnt = 0;
    ev(11);
    repeat (4) begin
      @(posedge clk);
      if (txAbortReq === 1'b1) cnt++;
    end
    chk(cnt, 8'h01);
    chk({7'h0, txChanOff}, 8'h01);
    rchk(IDX_LIVE, 8'h04);
    rchk(IDX_TXH1, 8'h10);
    rchk(IDX_LIVE, 8'h00);
    chk({7'h0, txChanOff}, 8'h00);
    wr(IDX_CTL, 8'h10);
    ev(12);
    rchk(IDX_TXH1, 8'h20);
    endT("transmit");
    // Status edges: sync, yellow, blue, red, line monitor
    lvlNow.sync_gone_flag = 1'b1;
    lv();
    rchk(IDX_ALARM, 8'h40);
    lvlNow.sync_gone_flag = 1'b0;
    lvlNow.remote_alarm_state = 1'b1;
    lvlNow.blue_alarm_flag = 1'b1;
    lvlNow.txOpen = 1'b1;
    lv();
    rchk(IDX_ALARM, 8'h89);
    rchk(IDX_TXH1, 8'h02);
    lvlNow.remote_alarm_state = 1'b0;
    lvlNow.blue_alarm_flag = 1'b0;
    lvlNow.txOpen = 1'b0;
    lv();
    rchk(IDX_ALARM, 8'h02);
    rchk(IDX_TXH1, 8'h00);
    wr(IDX_CTL, 8'h82);
    lvlNow.txShort = 1'b1;
    lvlNow.multi_sync_gone_flag = 1'b1;
    lv();
    rchk(IDX_ALARM, 8'h10);
    lvlNow.multi_sync_gone_flag = 1'b0;
    lvlNow.red_alarm_flag = 1'b1;
    lv();
    rchk(IDX_ALARM, 8'h24);
    lvlNow.red_alarm_flag = 1'b0;
    lvlNow.txShort = 1'b0;
    lv();
    rchk(IDX_ALARM, 8'h04);
    rchk(IDX_TXH1, 8'h02);
    lvlNow.alarmSim = 1'b1;
    lv();
    lvlNow.alarmSim = 1'b0;
    lv();
    rchk(IDX_ALARM, 8'hff);
    rchk(IDX_PERF, 8'h03);
    endT("status");
    // CAS empty in ESF with and without serial signaling, then every 24 frames in F12
    wr(IDX_CTL, 8'h40);
    ev(0);
    rchk(IDX_TXH1, 8'h88);
    wr(IDX_CTL, 8'h48);
    ev(0);
    rchk(IDX_TXH1, 8'h08);
    wr(IDX_CTL, 8'h80);
    repeat (23) ev(17);
    rchk(IDX_TXH1, 8'h00);
    ev(17);
    rchk(IDX_TXH1, 8'h80);
    endT("cas");
    // Two seconds of ticks, first with a code violation then clean
    wr(IDX_ERRMASK, 8'h02);
    ev(16);
    repeat (9) ev(15);
    rchk(IDX_PERF, 8'h00);
    ev(15);
    repeat (3) @(posedge clk);
    rchk(IDX_PERF, 8'hc0);
    repeat (10) ev(15);
    repeat (3) @(posedge clk);
    rchk(IDX_PERF, 8'h40);
    endT("second");
    // Loop-back code too short, then held long enough, then PRBS sync changes
    wr(IDX_CTL, 8'h00);
    lvlNow.llbCode = 1'b1;
    lvlNow.llbKindUp = 1'b1;
    lv();
    repeat (8) @(posedge clk);
    lvlNow.llbCode = 1'b0;
    lv();
    rchk(IDX_PERF, 8'h00);
    lvlNow.llbCode = 1'b1;
    lv();
    repeat (25) @(posedge clk);
    rchk(IDX_PERF, 8'h04);
    lvlNow.llbCode = 1'b0;
    lv();
    rchk(IDX_PERF, 8'h04);
    wr(IDX_CTL, 8'h04);
    lvlNow.prbsSync = 1'b1;
    lv();
    rchk(IDX_PERF, 8'h04);
    rchk(IDX_LIVE, 8'h01);
    lvlNow.prbsSync = 1'b0;
    lv();
    rchk(IDX_PERF, 8'h04);
    rchk(IDX_LIVE, 8'h00);
    endT("loopback");
    // Channel 2 frame start flag comes two bytes after the start
    ev(13);
    ev(14);
    rchk(IDX_SLIP, 8'h00);
    ev(14);
    rchk(IDX_SLIP, 8'h10);
    // Start and two bytes on consecutive cycles
    @(posedge clk);
    evt <= mkEvt(13);
    @(posedge clk);
    evt <= mkEvt(14);
    @(posedge clk);
    evt <= mkEvt(14);
    @(posedge clk);
    evt <= '0;
    rchk(IDX_SLIP, 8'h10);
    endT("start2");
    // SS7 error limit repeats on frame ticks until a valid frame arrives
    wr(IDX_CTL, 8'h20);
    ev(18);
    rchk(IDX_TXH1, 8'h04);
    ev(19);
    rchk(IDX_TXH1, 8'h04);
    ev(20);
    ev(19);
    rchk(IDX_TXH1, 8'h00);
    endT("ss7");
    close_out();
  end
endmodule
`default_nettype wire
